// ===== adcsc_top.sv
// Purpose : status flags, interrupts, result FIFO and channel mode of a SAR converter
// Assumes : converter delivers raw side samples; triggers arrive as one-cycle pulses
// Notes   : FIFO depth must be a power of two
//
// What this block does
// R1: overflow flag on push into full FIFO
// R2: ready flag while count exceeds watermark
// R3: trigger exception sets sticky exception flag
// R4: any trigger completion sets global done flag
// R5: calibration finish sets sticky calibration flag
// R6: active bit mirrors converter active state
// R7: overflow enable gates overflow interrupt
// R8: watermark enable gates ready interrupt
// R9: exception enable gates exception interrupt
// R10: per-trigger completion interrupt enables, sixteen slots
// R11: per-trigger interrupted flag on preemption
// R12: completed flag only when completion enabled
// R13: one scale mode drives both sides
// R14: divided or unity input scale
// R15: single-ended converts only selected side
// R16: differential result is A minus B, or B minus A in ADCSC_DIFF_BA mode
// R17: dual mode gives separate A, B results
// R18: single level interrupt from enabled flags
module adcsc_top #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST,
  // APB slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  input  wire logic [3:0]           PSTRB,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  // converter side
  input  wire adcsc_pkg::adcsc_sample_t SAMPLE,
  input  wire logic                 SAMPLE_VALID,
  output logic                      SAMPLE_READY,
  input  wire logic                 CONV_ACTIVE,
  input  wire logic                 CAL_DONE,
  output logic                      SCALE_SEL_A,
  output logic                      SCALE_SEL_B,
  // trigger events
  input  wire adcsc_pkg::adcsc_trig_t TRIG,
  // interrupt
  output logic                      IRQ
);

  // ----------------------------------------------------------------
  // local widths and state
  // ----------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][31:0]        mem;
    logic [AW-1:0]                 wptr;
    logic [AW-1:0]                 rptr;
    logic [CW-1:0]                 count;
    logic [adcsc_pkg::NUM_STAT-1:0] sticky;
    logic [adcsc_pkg::NUM_STAT-1:0] irq_en;
    logic [15:0]                   intr;
    logic [15:0]                   cmpl;
    logic [31:0]                   trig_en;
    adcsc_pkg::adcsc_scale_t       scale;
    adcsc_pkg::adcsc_mode_t        mode;
    logic [adcsc_pkg::WM_W-1:0]    wm;
    adcsc_pkg::adcsc_side_t        side;
    logic [31:0]                   pend;
    logic [31:0]                   rdata;
    logic                          err;
    logic                          irq;
  } adcsc_state_t;

  adcsc_state_t s;
  adcsc_state_t next_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] adcsc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : adcsc_merge

  // result word: side tag on top, signed 17-bit value at the bottom
  function automatic logic [31:0] adcsc_word(input logic                side_b,
                                             input logic [15:0] x,
                                             input logic [15:0] y,
                                             input logic                diff);
    logic [16:0] v;
    v = diff ? ({1'b0, x} - {1'b0, y}) : {1'b0, x};
    return {side_b, 14'h0000, v};
  endfunction : adcsc_word

  function automatic logic [31:0] adcsc_clr(input logic [31:0] wdata,
                                            input logic [3:0]  strb);
    return adcsc_merge(32'h0000_0000, wdata, strb);
  endfunction : adcsc_clr

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        wr;
  logic        mapped;
  logic [31:0] clr_word;

  always_comb begin
    setup    = PSEL & ~PENABLE;
    access   = PSEL & PENABLE;
    wr       = access & PWRITE;
    clr_word = adcsc_clr(PWDATA, PSTRB);
    unique case (PADDR)
      adcsc_pkg::OFF_STATUS,
      adcsc_pkg::OFF_STATUS_CLR,
      adcsc_pkg::OFF_IRQ_EN,
      adcsc_pkg::OFF_TRIG_STAT,
      adcsc_pkg::OFF_TRIG_CLR,
      adcsc_pkg::OFF_TRIG_EN,
      adcsc_pkg::OFF_CONFIG,
      adcsc_pkg::OFF_FIFO_DATA,
      adcsc_pkg::OFF_FIFO_COUNT: mapped = 1'b1;
      default:                   mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic                           push;
  logic                           push_ok;
  logic                           pop;
  logic                           full;
  logic                           ready_flag;
  logic [31:0]                    push_word;
  logic [adcsc_pkg::NUM_STAT-1:0] ev;
  logic [adcsc_pkg::NUM_STAT-1:0] stat_clr;
  logic [adcsc_pkg::NUM_STAT-1:0] status;
  logic [15:0]                    intr_clr;
  logic [15:0]                    cmpl_clr;
  logic [15:0]                    cmpl_set;
  logic [31:0]                    cfg_word;
  logic [31:0]                    trig_word;
  logic [31:0]                    rd_mux;
  logic [31:0]                    en_word;
  logic [31:0]                    cfg_new;

  always_comb begin
    next_s     = s;
    push       = 1'b0;
    push_word  = 32'h0000_0000;
    full       = (s.count == FULL_COUNT);
    ready_flag = (s.count > CW'(s.wm)); // R2
    pop        = access & ~PWRITE & (PADDR == adcsc_pkg::OFF_FIFO_DATA) & (s.count != '0);

    // channel mode sequencing; dual mode spends one extra cycle on side B
    if (s.side == adcsc_pkg::ADCSC_SIDE_B) begin
      push        = 1'b1; // R17
      push_word   = s.pend; // R17
      next_s.side = adcsc_pkg::ADCSC_SIDE_IDLE;
    end else if (SAMPLE_VALID) begin
      push = 1'b1;
      unique case (s.mode)
        adcsc_pkg::ADCSC_SINGLE_A: begin
          push_word = adcsc_word(1'b0, SAMPLE.channel_side_a, 16'h0000, 1'b0); // R15
        end
        adcsc_pkg::ADCSC_SINGLE_B: begin
          push_word = adcsc_word(1'b1, SAMPLE.channel_side_b, 16'h0000, 1'b0); // R15
        end
        adcsc_pkg::ADCSC_DIFF_AB,
        adcsc_pkg::ADCSC_DIFF_AB2: begin
          push_word = adcsc_word(1'b0, SAMPLE.channel_side_a, SAMPLE.channel_side_b, 1'b1); // R16
        end
        adcsc_pkg::ADCSC_DIFF_BA: begin
          push_word = adcsc_word(1'b1, SAMPLE.channel_side_b, SAMPLE.channel_side_a, 1'b1);
        end
        adcsc_pkg::ADCSC_DUAL: begin
          push_word   = adcsc_word(1'b0, SAMPLE.channel_side_a, 16'h0000, 1'b0); // R17
          next_s.pend = adcsc_word(1'b1, SAMPLE.channel_side_b, 16'h0000, 1'b0); // R17
          next_s.side = adcsc_pkg::ADCSC_SIDE_B;
        end
        default: begin
          push = 1'b0;
        end
      endcase
    end

    // result FIFO; a push into a full FIFO is dropped
    push_ok = push & ~full;
    if (push_ok) begin
      next_s.mem[s.wptr] = push_word;
      next_s.wptr        = s.wptr + AW'(1);
    end
    if (pop) begin
      next_s.rptr = s.rptr + AW'(1);
    end
    next_s.count = s.count + CW'(push_ok) - CW'(pop);

    // events
    ev                        = '0;
    ev[adcsc_pkg::BIT_OVF]    = push & full; // R1
    ev[adcsc_pkg::BIT_EXC]    = TRIG.exception; // R3
    ev[adcsc_pkg::BIT_DONE]   = |TRIG.done; // R4
    ev[adcsc_pkg::BIT_CAL]    = CAL_DONE; // R5
    cmpl_set                  = TRIG.done & s.trig_en[adcsc_pkg::TRIG_CMPL_LO +: 16]; // R12

    // software clears; a same-cycle event wins
    stat_clr = '0;
    intr_clr = '0;
    cmpl_clr = '0;
    if (wr && PADDR == adcsc_pkg::OFF_STATUS_CLR) begin
      stat_clr = clr_word[adcsc_pkg::NUM_STAT-1:0];
    end
    if (wr && PADDR == adcsc_pkg::OFF_TRIG_CLR) begin
      intr_clr = clr_word[15:0];
      cmpl_clr = clr_word[adcsc_pkg::TRIG_CMPL_LO +: 16];
    end
    next_s.sticky = ((s.sticky & ~stat_clr) | ev) & adcsc_pkg::STICKY_MASK; // R1 R3 R4 R5
    next_s.intr   = (s.intr & ~intr_clr) | TRIG.preempt; // R11
    next_s.cmpl   = (s.cmpl & ~cmpl_clr) | cmpl_set; // R12

    // live bits overlay the sticky ones
    status                        = s.sticky;
    status[adcsc_pkg::BIT_RDY]    = ready_flag; // R2
    status[adcsc_pkg::BIT_ACTIVE] = CONV_ACTIVE; // R6

    // writable registers
    cfg_word  = {19'h00000, s.wm, 4'h0, s.mode, s.scale};
    trig_word = {s.cmpl, s.intr};
    en_word   = adcsc_merge({26'h0, s.irq_en}, PWDATA, PSTRB);
    cfg_new   = adcsc_merge(cfg_word, PWDATA, PSTRB);
    if (wr) begin
      unique case (PADDR)
        adcsc_pkg::OFF_IRQ_EN: begin
          next_s.irq_en = en_word[adcsc_pkg::NUM_STAT-1:0];
        end
        adcsc_pkg::OFF_TRIG_EN: begin
          next_s.trig_en = adcsc_merge(s.trig_en, PWDATA, PSTRB); // R10
        end
        adcsc_pkg::OFF_CONFIG: begin
          next_s.scale = adcsc_pkg::adcsc_scale_t'(cfg_new[adcsc_pkg::CFG_SCALE]); // R14
          next_s.mode  = adcsc_pkg::adcsc_mode_t'(cfg_new[adcsc_pkg::CFG_MODE_LO +: 3]);
          next_s.wm    = cfg_new[adcsc_pkg::CFG_WM_LO +: adcsc_pkg::WM_W];
        end
        default: begin
        end
      endcase
    end

    // read data is latched in the setup cycle so it comes from a flop
    unique case (PADDR)
      adcsc_pkg::OFF_STATUS:     rd_mux = {26'h0000000, status};
      adcsc_pkg::OFF_IRQ_EN:     rd_mux = {26'h0000000, s.irq_en};
      adcsc_pkg::OFF_TRIG_STAT:  rd_mux = trig_word;
      adcsc_pkg::OFF_TRIG_EN:    rd_mux = s.trig_en;
      adcsc_pkg::OFF_CONFIG:     rd_mux = cfg_word;
      adcsc_pkg::OFF_FIFO_DATA:  rd_mux = (s.count != '0) ? s.mem[s.rptr] : 32'h0000_0000;
      adcsc_pkg::OFF_FIFO_COUNT: rd_mux = 32'(s.count);
      default:                   rd_mux = 32'h0000_0000;
    endcase
    if (setup) begin
      next_s.rdata = PWRITE ? 32'h0000_0000 : rd_mux;
      next_s.err   = ~mapped;
    end

    // interrupt level from enabled flags
    next_s.irq = |(status & s.irq_en)                        // R7 R8 R9 R18
               | |(s.intr & s.trig_en[15:0])                 // R18
               | |(s.cmpl & s.trig_en[adcsc_pkg::TRIG_CMPL_LO +: 16]); // R10 R18
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      s         <= '0;
      s.irq_en  <= adcsc_pkg::IRQ_EN_RESET;
      s.trig_en <= adcsc_pkg::TRIG_EN_RESET;
      s.scale   <= adcsc_pkg::adcsc_scale_t'(adcsc_pkg::SCALE_RESET);
      s.mode    <= adcsc_pkg::ADCSC_SINGLE_A;
      s.wm      <= adcsc_pkg::WM_RESET;
      s.side    <= adcsc_pkg::ADCSC_SIDE_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero wait states: every access phase completes at once
  assign PREADY       = 1'b1;
  assign PRDATA       = s.rdata;
  assign PSLVERR      = s.err & PSEL & PENABLE;
  assign SAMPLE_READY = (s.side == adcsc_pkg::ADCSC_SIDE_IDLE);
  // one flop feeds both sides, so they can never disagree
  assign SCALE_SEL_A  = s.scale; // R13
  assign SCALE_SEL_B  = s.scale; // R13
  assign IRQ          = s.irq;

endmodule : adcsc_top

// ===== adcsc_pkg.sv
// Purpose : shared constants and types of the converter status, interrupt and channel block
// Assumes : 32-bit APB, one aligned word per register
// Notes   : status and enable registers share one bit layout
package adcsc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS     = 8'h00;
  localparam logic [7:0] OFF_STATUS_CLR = 8'h04;
  localparam logic [7:0] OFF_IRQ_EN     = 8'h08;
  localparam logic [7:0] OFF_TRIG_STAT  = 8'h0c;
  localparam logic [7:0] OFF_TRIG_CLR   = 8'h10;
  localparam logic [7:0] OFF_TRIG_EN    = 8'h14;
  localparam logic [7:0] OFF_CONFIG     = 8'h18;
  localparam logic [7:0] OFF_FIFO_DATA  = 8'h1c;
  localparam logic [7:0] OFF_FIFO_COUNT = 8'h20;

  // ----------------------------------------------------------------
  // status / enable bit positions
  // ----------------------------------------------------------------
  localparam int BIT_OVF    = 0;
  localparam int BIT_RDY    = 1;
  localparam int BIT_EXC    = 2;
  localparam int BIT_DONE   = 3;
  localparam int BIT_CAL    = 4;
  localparam int BIT_ACTIVE = 5;
  localparam int NUM_STAT   = 6;
  localparam logic [5:0] STICKY_MASK = 6'h1d;

  // ----------------------------------------------------------------
  // trigger slots and config fields
  // ----------------------------------------------------------------
  localparam int NUM_TRIG     = 16;
  localparam int TRIG_CMPL_LO = 16;
  localparam int CFG_SCALE    = 0;
  localparam int CFG_MODE_LO  = 1;
  localparam int CFG_WM_LO    = 8;
  localparam int WM_W         = 5;
  localparam int SAMPLE_W     = 16;
  localparam int RES_SIDE_BIT = 31;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0]  IRQ_EN_RESET  = 6'h00;
  localparam logic [31:0] TRIG_EN_RESET = 32'h0000_0000;
  localparam logic        SCALE_RESET   = 1'b0;
  localparam logic [WM_W-1:0] WM_RESET  = 5'h00;

  // ----------------------------------------------------------------
  // modes and types
  // ----------------------------------------------------------------
  typedef enum logic {
    ADCSC_DIVIDED_INPUT_SCALE = 1'b0,
    ADCSC_UNITY_INPUT_SCALE   = 1'b1
  } adcsc_scale_t;

  typedef enum logic [2:0] {
    ADCSC_SINGLE_A = 3'h0,
    ADCSC_SINGLE_B = 3'h1,
    ADCSC_DIFF_AB  = 3'h2,
    ADCSC_DIFF_BA  = 3'h3,
    ADCSC_DIFF_AB2 = 3'h4,
    ADCSC_DUAL     = 3'h5
  } adcsc_mode_t;

  typedef enum logic {
    ADCSC_SIDE_IDLE = 1'b0,
    ADCSC_SIDE_B    = 1'b1
  } adcsc_side_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] channel_side_a;
    logic [SAMPLE_W-1:0] channel_side_b;
  } adcsc_sample_t;

  typedef struct packed {
    logic [NUM_TRIG-1:0] done;
    logic [NUM_TRIG-1:0] preempt;
    logic                exception;
  } adcsc_trig_t;

endpackage : adcsc_pkg

// ===== adcsc_chk_asserts.sv
// Purpose : port checks of the converter status block
// Assumes : bench writes with all byte strobes on
// Notes   : enable shadows ignore PSTRB
module adcsc_chk (
  // clock and reset
  input wire logic                   CLK,
  input wire logic                   RST,
  // register bus
  input wire logic                   PSEL,
  input wire logic                   PENABLE,
  input wire logic                   PWRITE,
  input wire logic [7:0]             PADDR,
  input wire logic [31:0]            PWDATA,
  input wire logic [31:0]            PRDATA,
  // converter side
  input wire logic                   CONV_ACTIVE,
  input wire logic                   CAL_DONE,
  input wire logic                   SCALE_SEL_A,
  input wire logic                   SCALE_SEL_B,
  input wire adcsc_pkg::adcsc_trig_t TRIG,
  input wire logic                   IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [5:0]  en;
  logic [31:0] ten;
  wire         wr = PSEL && PENABLE && PWRITE;
  wire         clr_wr = wr && PADDR == adcsc_pkg::OFF_STATUS_CLR;
  always_ff @(posedge CLK) begin
    if (RST) begin
      en  <= 6'h00;
      ten <= 32'h0;
    end else if (wr && PADDR == adcsc_pkg::OFF_IRQ_EN) begin
      en <= PWDATA[5:0];
    end else if (wr && PADDR == adcsc_pkg::OFF_TRIG_EN) begin
      ten <= PWDATA;
    end
  end
  sequence stat_rd;
    PSEL && !PENABLE && !PWRITE && PADDR == adcsc_pkg::OFF_STATUS;
  endsequence
  // a clear write between event and read may legally empty the flag
  sequence ev_to_rd(ev);
    ev ##1 !clr_wr ##1 stat_rd;
  endsequence
  scale_equal_a: assert property (SCALE_SEL_A == SCALE_SEL_B) else $error("scale sides differ");
  active_live_a: assert property (stat_rd |=> PRDATA[5] == $past(CONV_ACTIVE))
    else $error("active bit wrong");
  exc_sticky_a: assert property (ev_to_rd(TRIG.exception) |=> PRDATA[2]) else $error("no exception flag");
  done_sticky_a: assert property (ev_to_rd(|TRIG.done) |=> PRDATA[3]) else $error("no done flag");
  cal_sticky_a: assert property (ev_to_rd(CAL_DONE) |=> PRDATA[4]) else $error("no calibration flag");
  irq_exc_a: assert property (TRIG.exception && en[2] |-> ##2 IRQ) else $error("no exception irq");
  irq_cmpl_a: assert property (|(TRIG.done & ten[31:16]) |-> ##2 IRQ) else $error("no completion irq");
  irq_pre_a: assert property (|(TRIG.preempt & ten[15:0]) |-> ##2 IRQ) else $error("no preempt irq");
  irq_quiet_a: assert property ((en == 6'h00 && ten == 32'h0) [*2] |-> !IRQ) else $error("irq unmasked");
endmodule : adcsc_chk

bind adcsc_top adcsc_chk u_adcsc_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .CONV_ACTIVE(CONV_ACTIVE), .CAL_DONE(CAL_DONE),
  .SCALE_SEL_A(SCALE_SEL_A), .SCALE_SEL_B(SCALE_SEL_B), .TRIG(TRIG), .IRQ(IRQ));

// ===== adcsc_conv_model.sv
// Purpose : converter and trigger sources facing the block
// Assumes : driven from bench tasks, one edge apart
// Notes   : released sample bus shows inverted data
module adcsc_conv_model (
  // clock
  input wire logic                  CLK,
  // converter side
  input wire logic                  SAMPLE_READY,
  output adcsc_pkg::adcsc_sample_t  SAMPLE,
  output logic                      SAMPLE_VALID,
  output logic                      CAL_DONE,
  // trigger events
  output adcsc_pkg::adcsc_trig_t    TRIG
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    SAMPLE       = 32'h0;
    SAMPLE_VALID = 1'b0;
    CAL_DONE     = 1'b0;
    TRIG         = 33'h0;
  end
  // gap gives a slow converter
  task send(input logic [15:0] a, input logic [15:0] b, input int gap);
    repeat (gap + 1) @(posedge CLK);
    SAMPLE       <= {a, b};
    SAMPLE_VALID <= 1'b1;
    @(posedge CLK);
    while (SAMPLE_READY !== 1'b1) @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
    SAMPLE       <= ~{a, b};
  endtask : send
  task pulse(input adcsc_pkg::adcsc_trig_t t, input logic cal);
    @(posedge CLK);
    TRIG     <= t;
    CAL_DONE <= cal;
    @(posedge CLK);
    TRIG     <= 33'h0;
    CAL_DONE <= 1'b0;
  endtask : pulse
endmodule : adcsc_conv_model

// ===== tb_top.sv
// Purpose : self-checking bench of the converter status block
// Assumes : zero-wait APB, full byte strobes
// Notes   : row table covers channel modes
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {adcsc_pkg::adcsc_mode_t m; logic s; logic [15:0] a, b; logic [31:0] w0, w1; int n;} adcsc_row_t;
  logic                     CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
  logic [7:0]               PADDR;
  logic [31:0]              PWDATA, PRDATA, rd;
  logic                     SAMPLE_VALID, SAMPLE_READY, CONV_ACTIVE, CAL_DONE, SCALE_SEL_A, SCALE_SEL_B, IRQ;
  adcsc_pkg::adcsc_sample_t SAMPLE;
  adcsc_pkg::adcsc_trig_t   TRIG;
  int                       errors, comparisons;
  adcsc_row_t rows[6] = '{
    '{adcsc_pkg::ADCSC_SINGLE_A, 1'b0, 16'h1234, 16'h5678, 32'h0000_1234, 32'h0, 1},
    '{adcsc_pkg::ADCSC_SINGLE_B, 1'b1, 16'h1234, 16'h5678, 32'h8000_5678, 32'h0, 1},
    '{adcsc_pkg::ADCSC_DIFF_AB, 1'b0, 16'h0010, 16'h0030, 32'h0001_ffe0, 32'h0, 1},
    '{adcsc_pkg::ADCSC_DIFF_AB2, 1'b1, 16'h0030, 16'h0010, 32'h0000_0020, 32'h0, 1},
    '{adcsc_pkg::ADCSC_DIFF_BA, 1'b0, 16'h0010, 16'h0030, 32'h8000_0020, 32'h0, 1},
    '{adcsc_pkg::ADCSC_DUAL, 1'b0, 16'h1234, 16'h5678, 32'h0000_1234, 32'h8000_5678, 2}};

  adcsc_top u_adcsc_top (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(4'hf), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE(SAMPLE),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY), .CONV_ACTIVE(CONV_ACTIVE), .CAL_DONE(CAL_DONE),
    .SCALE_SEL_A(SCALE_SEL_A), .SCALE_SEL_B(SCALE_SEL_B), .TRIG(TRIG), .IRQ(IRQ));
  adcsc_conv_model u_adcsc_conv_model (.CLK(CLK), .SAMPLE_READY(SAMPLE_READY), .SAMPLE(SAMPLE),
    .SAMPLE_VALID(SAMPLE_VALID), .CAL_DONE(CAL_DONE), .TRIG(TRIG));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one idle edge first, so back-to-back calls never drive twice at one edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk

  initial begin
    repeat (6000) @(posedge CLK);
    errors++;
    test_done;
  end

  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, CONV_ACTIVE, err, rd} = '0;
    RST = 1'b1;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, adcsc_pkg::OFF_CONFIG, {28'h0, rows[i].m, rows[i].s});
      u_adcsc_conv_model.send(rows[i].a, rows[i].b, i);
      chk("scale", rows[i].s, SCALE_SEL_A);
      chk("scale b", rows[i].s, SCALE_SEL_B);
      rdchk("count", adcsc_pkg::OFF_FIFO_COUNT, rows[i].n);
      rdchk("word0", adcsc_pkg::OFF_FIFO_DATA, rows[i].w0);
      if (rows[i].n == 2) rdchk("word1", adcsc_pkg::OFF_FIFO_DATA, rows[i].w1);
      $display("test mode row %0d done", i);
    end
    apb(1'b1, adcsc_pkg::OFF_CONFIG, 32'h0000_0200);
    apb(1'b1, adcsc_pkg::OFF_IRQ_EN, 32'h2);
    repeat (3) u_adcsc_conv_model.send(16'h0001, 16'h0002, 0);
    rdchk("ready", adcsc_pkg::OFF_STATUS, 32'h2);
    chk("irq ready", 1'b1, IRQ);
    apb(1'b0, adcsc_pkg::OFF_FIFO_DATA, 32'h0);
    rdchk("not ready", adcsc_pkg::OFF_STATUS, 32'h0);
    chk("irq ready off", 1'b0, IRQ);
    $display("test watermark done");
    apb(1'b1, adcsc_pkg::OFF_IRQ_EN, 32'h1);
    repeat (14) u_adcsc_conv_model.send(16'h0003, 16'h0004, 0);
    rdchk("full", adcsc_pkg::OFF_STATUS, 32'h2);
    u_adcsc_conv_model.send(16'h0005, 16'h0006, 0);
    rdchk("count", adcsc_pkg::OFF_FIFO_COUNT, 32'd16);
    rdchk("overflow", adcsc_pkg::OFF_STATUS, 32'h3);
    chk("irq ovf", 1'b1, IRQ);
    apb(1'b1, adcsc_pkg::OFF_STATUS_CLR, 32'h1);
    rdchk("ovf cleared", adcsc_pkg::OFF_STATUS, 32'h2);
    chk("irq ovf off", 1'b0, IRQ);
    repeat (16) apb(1'b0, adcsc_pkg::OFF_FIFO_DATA, 32'h0);
    rdchk("empty", adcsc_pkg::OFF_FIFO_COUNT, 32'h0);
    $display("test overflow done");
    CONV_ACTIVE <= 1'b1;
    apb(1'b1, adcsc_pkg::OFF_IRQ_EN, 32'h4);
    u_adcsc_conv_model.pulse(33'h1, 1'b0);
    rdchk("exception", adcsc_pkg::OFF_STATUS, 32'h24);
    chk("irq exc", 1'b1, IRQ);
    u_adcsc_conv_model.pulse(33'h0, 1'b1);
    rdchk("calibrated", adcsc_pkg::OFF_STATUS, 32'h34);
    apb(1'b1, adcsc_pkg::OFF_STATUS_CLR, 32'h1d);
    rdchk("cleared", adcsc_pkg::OFF_STATUS, 32'h20);
    chk("irq exc off", 1'b0, IRQ);
    $display("test events done");
    apb(1'b1, adcsc_pkg::OFF_TRIG_EN, 32'h0001_0000);
    u_adcsc_conv_model.pulse(33'h0_0007_0000, 1'b0);
    rdchk("global done", adcsc_pkg::OFF_STATUS, 32'h28);
    rdchk("trig flags", adcsc_pkg::OFF_TRIG_STAT, 32'h0001_8000);
    chk("irq cmpl", 1'b1, IRQ);
    apb(1'b1, adcsc_pkg::OFF_TRIG_CLR, 32'hffff_ffff);
    apb(1'b1, adcsc_pkg::OFF_TRIG_EN, 32'h0000_8000);
    chk("irq cmpl off", 1'b0, IRQ);
    u_adcsc_conv_model.pulse(33'h0_0001_0000, 1'b0);
    rdchk("preempt", adcsc_pkg::OFF_TRIG_STAT, 32'h0000_8000);
    chk("irq preempt", 1'b1, IRQ);
    $display("test triggers done");
    rdchk("unmapped", 8'h24, 32'h0);
    chk("slverr", 1'b1, err);
    @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rdchk("irq en rst", adcsc_pkg::OFF_IRQ_EN, 32'h0);
    rdchk("trig en rst", adcsc_pkg::OFF_TRIG_EN, 32'h0);
    rdchk("config rst", adcsc_pkg::OFF_CONFIG, 32'h0);
    chk("irq rst", 1'b0, IRQ);
    chk("pready", 1'b1, PREADY);
    chk("slverr ok", 1'b0, err);
    $display("test reset done");
    test_done;
  end
endmodule : tb_top
